// ### logic/csm_channel_status.sv
// Operation
// - bit 0 of the mux enable register doubles channel 1 onto channel 0.
// - bit 1 of the mux enable register doubles channel 3 onto channel 2.
// - status bits 15..12 are the OR of each channel's accumulated fail bits.
// - status bits 11..8 are the OR of each channel's timing error flags.
// - status bits 7,5,3,1 show the high comparator of channels 3..0.
// - status bits 6,4,2,0 show the low comparator of channels 3..0.
// - arm, start and stop each pick any channel's high or low comparator.
// - each measurement output tristates under its own enable bit.
// - stop, start, arm codes sit in 10:8, 6:4, 2:0; 2n high, 2n+1 low.
// - enables sit in bits 11, 7, 3, zero tristates, all reset to zero.
`timescale 1ns/1ps
`default_nettype none

module csm_channel_status #(
    // arbitrary value, not tied to any part
    parameter logic [15:0] CHIP_INFO = 16'h0000
) (
    // clock and reset
    input  wire logic                                    clock,
    input  wire logic                                    arst_n,
    // wishbone classic slave
    input  wire logic                                    cyc_i,
    input  wire logic                                    stb_i,
    input  wire logic                                    we_i,
    input  wire logic [csm_pkg::ADR_W-1:0]               adr_i,
    input  wire logic [3:0]                              sel_i,
    input  wire logic [31:0]                             dat_i,
    output var  logic [31:0]                             dat_o,
    output var  logic                                    ack_o,
    // channel state
    input  wire logic [csm_pkg::NCH-1:0]                 compHigh,
    input  wire logic [csm_pkg::NCH-1:0]                 compLow,
    input  wire logic [csm_pkg::NCH-1:0][csm_pkg::FAIL_W-1:0]
                                                         accumulatedFailReg,
    input  wire logic [csm_pkg::NCH-1:0][csm_pkg::TERR_W-1:0]
                                                         timingErrFlags,
    // channel pairing
    output var  logic                                    muxPair01,
    output var  logic                                    muxPair23,
    // measurement unit outputs
    output var  logic                                    measureArmOut,
    output var  logic                                    measureArmOe,
    output var  logic                                    measureBeginOut,
    output var  logic                                    measureBeginOe,
    output var  logic                                    measureEndOut,
    output var  logic                                    measureEndOe,
    // interrupt
    output var  logic                                    irq
);
    import csm_pkg::*;

    csm_meas_sel_s     measSel_q;
    csm_word_t         muxEn_q;
    csm_event_s        irqStat_q;
    csm_event_s        irqMask_q;
    logic              ack_q;
    logic [31:0]       datOut_q;
    logic [NCH-1:0]    failPrev_q;
    logic [NCH-1:0]    terrPrev_q;
    logic [NCH-1:0]    compHighSync;
    logic [NCH-1:0]    compLowSync;
    logic [NCH-1:0]    failOr;
    logic [NCH-1:0]    terrOr;
    logic [2*NCH-1:0]  compPairs;
    csm_word_t         statusWord;
    csm_event_s        evtNow;
    csm_event_s        irqStat_d;
    logic [31:0]       readData;

    // bus decode
    wire              request  = cyc_i & stb_i;
    wire              ackSet   = request & ~ack_q;
    wire              wrFire   = request & we_i & ack_q;
    wire [IDX_W-1:0]  regIdx   = adr_i[ADR_W-1:2];
    wire              hitMeas  = regIdx == IDX_MEAS_SEL;
    wire              hitMux   = regIdx == IDX_MUX_EN;
    wire              hitStat  = regIdx == IDX_STATUS;
    wire              hitChip  = regIdx == IDX_CHIP_INFO;
    wire              hitIrqS  = regIdx == IDX_IRQ_STAT;
    wire              hitIrqM  = regIdx == IDX_IRQ_MASK;
    wire [15:0]       laneMask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
    wire [15:0]       wrLow    = dat_i[15:0];

    // comparators cross into the clock domain before status use
    // two-stage synchroniser
    csm_sync #(
        .W      (2 * NCH)
    ) u_comp_sync (
        .clock  (clock),
        .arst_n (arst_n),
        .d      ({compHigh, compLow}),
        .q      ({compHighSync, compLowSync})
    );

    // per-channel summaries and live comparator pairs
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            failOr[c] = |accumulatedFailReg[c];
            terrOr[c] = |timingErrFlags[c];
            compPairs[2*c+1] = compHighSync[c];
            compPairs[2*c]   = compLowSync[c];
        end
    end

    assign statusWord = {failOr, terrOr, compPairs};

    // summary rising edges are the interrupt events
    assign evtNow.fail = failOr & ~failPrev_q;
    assign evtNow.terr = terrOr & ~terrPrev_q;

    always_comb begin
        irqStat_d = irqStat_q;
        if (wrFire && hitIrqS && sel_i[0]) begin
            irqStat_d = irqStat_d & ~csm_event_s'(wrLow[7:0]);
        end
        // a new event outranks a clear in the same cycle
        irqStat_d = irqStat_d | evtNow;
    end

    assign irq = |(irqStat_q & irqMask_q);

    // read mux, unmapped indices read zero and still acknowledge
    always_comb begin
        readData = 32'h0000_0000;
        if (hitMeas) begin
            readData[15:0] = csm_word_t'(measSel_q);
        end else if (hitMux) begin
            readData[15:0] = muxEn_q;
        end else if (hitStat) begin
            readData[15:0] = statusWord;
        end else if (hitChip) begin
            readData[15:0] = CHIP_INFO;
        end else if (hitIrqS) begin
            readData[7:0] = irqStat_q;
        end else if (hitIrqM) begin
            readData[7:0] = irqMask_q;
        end
    end

    // one wait state, ack drops the cycle after it was given
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ack_q    <= 1'b0;
            datOut_q <= 32'h0000_0000;
        end else begin
            ack_q <= ackSet;
            if (ackSet && !we_i) begin
                datOut_q <= readData;
            end
        end
    end

    assign ack_o = ack_q;
    assign dat_o = datOut_q;

    // writable registers commit on the acknowledged edge
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            measSel_q <= csm_meas_sel_s'(MEAS_SEL_RST);
            muxEn_q   <= MUX_EN_RST;
            irqMask_q <= csm_event_s'(IRQ_RST);
        end else if (wrFire) begin
            // select fields written by byte lane
            // enable bits written by byte lane
            if (hitMeas) begin
                measSel_q <= csm_meas_sel_s'(
                    (csm_word_t'(measSel_q) & ~laneMask)
                    | (wrLow & laneMask & MEAS_SEL_MASK));
            end
            if (hitMux) begin
                muxEn_q <= (muxEn_q & ~laneMask)
                    | (wrLow & laneMask & MUX_EN_MASK);
            end
            if (hitIrqM && sel_i[0]) begin
                irqMask_q <= csm_event_s'(wrLow[7:0]);
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            irqStat_q  <= csm_event_s'(IRQ_RST);
            failPrev_q <= '0;
            terrPrev_q <= '0;
        end else begin
            irqStat_q  <= irqStat_d;
            failPrev_q <= failOr;
            terrPrev_q <= terrOr;
        end
    end

    // channel 1 doubled onto channel 0
    assign muxPair01 = muxEn_q[MUX_PAIR01_BIT];
    // channel 3 doubled onto channel 2
    assign muxPair23 = muxEn_q[MUX_PAIR23_BIT];

    // raw comparators drive the measurement path: a register here
    // would quantise edges to the 50 ns clock and ruin the timing
    // independent comparator pick per output
    // code 2n high, 2n+1 low of channel n
    wire armPick   = measSel_q.armSel[0]
                   ? compLow[measSel_q.armSel[2:1]]
                   : compHigh[measSel_q.armSel[2:1]];
    wire startPick = measSel_q.startSel[0]
                   ? compLow[measSel_q.startSel[2:1]]
                   : compHigh[measSel_q.startSel[2:1]];
    wire stopPick  = measSel_q.stopSel[0]
                   ? compLow[measSel_q.stopSel[2:1]]
                   : compHigh[measSel_q.stopSel[2:1]];

    // each output released on its own enable
    assign measureArmOe    = measSel_q.armEn;
    assign measureBeginOe  = measSel_q.startEn;
    assign measureEndOe    = measSel_q.stopEn;
    assign measureArmOut   = measSel_q.armEn & armPick;
    assign measureBeginOut = measSel_q.startEn & startPick;
    assign measureEndOut   = measSel_q.stopEn & stopPick;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    wire statRead = ack_o && !we_i && hitStat;

    pair01_write_a: assert property (
        wrFire && hitMux && sel_i[0]
        |=> muxPair01 == $past(dat_i[0]))
        else $error("pairing 0/1 did not follow write");

    pair23_write_a: assert property (
        wrFire && hitMux && sel_i[0]
        |=> muxPair23 == $past(dat_i[1]) && muxPair01 == $past(dat_i[0]))
        else $error("pairing 2/3 did not follow write");

    fail_summary_a: assert property (
        statRead |-> dat_o[15:12] == $past(failOr))
        else $error("fail summary bits wrong");

    terr_summary_a: assert property (
        statRead |-> dat_o[11:8] == $past(terrOr))
        else $error("timing error summary bits wrong");

    comp_high_a: assert property (
        statRead |-> {dat_o[7], dat_o[5], dat_o[3], dat_o[1]}
                     == $past(compHigh, 3))
        else $error("high comparator bits wrong");

    comp_low_a: assert property (
        statRead |-> {dat_o[6], dat_o[4], dat_o[2], dat_o[0]}
                     == $past(compLow, 3))
        else $error("low comparator bits wrong");

    arm_route_a: assert property (
        measSel_q.armEn && measSel_q.armSel == 3'h5
        |-> measureArmOut == compLow[2])
        else $error("arm output not routed from channel 2 low");

    stop_route_a: assert property (
        measSel_q.stopEn && measSel_q.stopSel == 3'h6
        |-> measureEndOut == compHigh[3])
        else $error("stop output not routed from channel 3 high");

    begin_tristate_a: assert property (
        wrFire && hitMeas && sel_i[0] && !dat_i[7]
        |=> !measureBeginOe && !measureBeginOut)
        else $error("start output still driven when disabled");

    sel_fields_a: assert property (
        wrFire && hitMeas && (&sel_i[1:0])
        |=> measSel_q.stopSel == $past(dat_i[10:8])
            && measSel_q.startSel == $past(dat_i[6:4])
            && measSel_q.armSel == $past(dat_i[2:0]))
        else $error("select fields not taken from write");

    enable_bits_a: assert property (
        wrFire && hitMeas && (&sel_i[1:0])
        |=> measureEndOe == $past(dat_i[11])
            && measureBeginOe == $past(dat_i[7])
            && measureArmOe == $past(dat_i[3]))
        else $error("enable bits not taken from write");

    event_sticky_a: assert property (
        (|evtNow) |=> (irqStat_q & $past(evtNow)) == $past(evtNow))
        else $error("event lost against clear");

    ack_single_a: assert property (
        ack_o |=> !ack_o)
        else $error("ack held for more than one cycle");

    ack_follows_a: assert property (
        cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack missing in the cycle after a request");

    read_hold_a: assert property (
        !ack_o |-> $stable(dat_o))
        else $error("read data changed outside an acknowledge");

    upper_zero_a: assert property (
        ack_o && !we_i |-> dat_o[31:16] == 16'h0000)
        else $error("read data above bit 15 not zero");

    start_route_a: assert property (
        measSel_q.startEn && measSel_q.startSel == 3'h2
        |-> measureBeginOut == compHigh[1])
        else $error("start output not routed from channel 1 high");

    arm_tristate_a: assert property (
        wrFire && hitMeas && sel_i[0] && !dat_i[3]
        |=> !measureArmOe && !measureArmOut)
        else $error("arm output still driven when disabled");

    end_tristate_a: assert property (
        wrFire && hitMeas && sel_i[1] && !dat_i[11]
        |=> !measureEndOe && !measureEndOut)
        else $error("stop output still driven when disabled");

    lane_hold_a: assert property (
        wrFire && hitMeas && !sel_i[1]
        |=> measSel_q.stopSel == $past(measSel_q.stopSel)
            && measSel_q.stopEn == $past(measSel_q.stopEn))
        else $error("stop field changed by a lane 0 write");

    readonly_write_a: assert property (
        wrFire && (hitStat || hitChip)
        |=> muxEn_q == $past(muxEn_q)
            && measSel_q == $past(measSel_q))
        else $error("control changed by a read-only write");

    irq_clear_a: assert property (
        wrFire && hitIrqS && sel_i[0] && !(|evtNow)
        |=> (irqStat_q & $past(dat_i[7:0])) == 8'h00)
        else $error("interrupt status bit not cleared by write");

    irq_mask_a: assert property (
        wrFire && hitIrqM && sel_i[0]
        |=> irqMask_q == $past(dat_i[7:0]))
        else $error("interrupt mask not taken from write");

endmodule

`default_nettype wire

// ### logic/csm_pkg.sv
package csm_pkg;

    // channel geometry
    localparam int unsigned NCH    = 4;
    localparam int unsigned FAIL_W = 8;
    localparam int unsigned TERR_W = 4;
    localparam int unsigned ADR_W  = 8;
    localparam int unsigned IDX_W  = 6;

    // register indices, byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_MEAS_SEL  = 6'h1C;
    localparam logic [IDX_W-1:0] IDX_MUX_EN    = 6'h1D;
    localparam logic [IDX_W-1:0] IDX_STATUS    = 6'h1E;
    localparam logic [IDX_W-1:0] IDX_CHIP_INFO = 6'h1F;
    localparam logic [IDX_W-1:0] IDX_IRQ_STAT  = 6'h20;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK  = 6'h21;

    // reset values and writable-bit masks
    localparam logic [15:0] MEAS_SEL_RST  = 16'h0000;
    localparam logic [15:0] MEAS_SEL_MASK = 16'h0FFF;
    localparam logic [15:0] MUX_EN_RST    = 16'h0000;
    localparam logic [15:0] MUX_EN_MASK   = 16'h0003;
    localparam logic [7:0]  IRQ_RST       = 8'h00;

    // field positions
    localparam int unsigned MUX_PAIR01_BIT = 0;
    localparam int unsigned MUX_PAIR23_BIT = 1;
    localparam int unsigned STAT_FAIL_LSB  = 12;
    localparam int unsigned STAT_TERR_LSB  = 8;

    typedef logic [15:0] csm_word_t;

    // measurement select register layout
    typedef struct packed {
        logic [3:0] unused;
        logic       stopEn;
        logic [2:0] stopSel;
        logic       startEn;
        logic [2:0] startSel;
        logic       armEn;
        logic [2:0] armSel;
    } csm_meas_sel_s;

    // interrupt status and mask layout
    typedef struct packed {
        logic [NCH-1:0] fail;
        logic [NCH-1:0] terr;
    } csm_event_s;

endpackage

// ### logic/csm_sync.sv
`timescale 1ns/1ps
`default_nettype none

module csm_sync #(
    parameter int unsigned W = 1
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         arst_n,
    // data
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);

    logic [W-1:0] stage1_q;

    // first stage feeds only the second
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            stage1_q <= '0;
            q        <= '0;
        end else begin
            stage1_q <= d;
            q        <= stage1_q;
        end
    end

endmodule

`default_nettype wire

// ### testbench/csm_tmu_model.sv
`timescale 1ns/1ps
`default_nettype none

module csm_measure_model (
    // clock
    input  wire logic       clock,
    // device outputs: 0 arm, 1 begin, 2 end
    input  wire logic [2:0] lineOut,
    input  wire logic [2:0] lineOe,
    // levels seen by the measurement unit
    output var  logic [2:0] busLevel
);
    logic [2:0] lastLevel_q = 3'h0;

    // board picks driver
    // an undriven bus has no keeper, so it shows a toggling level
    assign busLevel = (lineOe & lineOut) | (~lineOe & ~lastLevel_q);

    always_ff @(posedge clock) begin
        lastLevel_q <= busLevel;
    end
endmodule

`default_nettype wire

// ### testbench/channel_status_mux_control_bench.sv
`timescale 1ns/1ps
`default_nettype none

module channel_status_mux_control_bench;
    import csm_pkg::*;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h3;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic ack;
    logic [NCH-1:0] compHigh = 4'h0;
    logic [NCH-1:0] compLow = 4'h0;
    logic [NCH-1:0][FAIL_W-1:0] failIn = '0;
    logic [NCH-1:0][TERR_W-1:0] terrIn = '0;
    logic pair01, pair23, irq;
    wire  [2:0] lineOut, lineOe, busLevel;
    int numErrors = 0;
    int nChecks = 0;

    csm_channel_status DUT (.clock(clock), .arst_n(arst_n), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
        .dat_o(rdat), .ack_o(ack), .compHigh(compHigh), .compLow(compLow),
        .accumulatedFailReg(failIn), .timingErrFlags(terrIn),
        .muxPair01(pair01), .muxPair23(pair23),
        .measureArmOut(lineOut[0]), .measureArmOe(lineOe[0]),
        .measureBeginOut(lineOut[1]), .measureBeginOe(lineOe[1]),
        .measureEndOut(lineOut[2]), .measureEndOe(lineOe[2]), .irq(irq));

    csm_measure_model meas (.clock(clock), .lineOut(lineOut), .lineOe(lineOe),
        .busLevel(busLevel));

    initial begin
        forever #25 clock = ~clock;
    end

    task automatic finish_test;
        $display("checks %0d errors %0d", nChecks, numErrors);
        if (numErrors == 0 && nChecks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        nChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // holds the request until ack is sampled, then idles a cycle
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [15:0] d, output logic [31:0] r);
        int i;
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {16'h0000, d};
        i = 0;
        do begin
            @(posedge clock);
            i++;
        end while (ack !== 1'b1 && i < 20);
        if (ack !== 1'b1) begin
            numErrors++;
            finish_test;
        end else begin
            r = rdat;
            cyc <= 1'b0;
            stb <= 1'b0;
            @(posedge clock);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, r);
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        logic [31:0] r;
        wb(1'b0, a, 16'h0000, r);
        chk_word(r, {16'h0000, e});
    endtask

    function automatic logic pick(input logic [2:0] c);
        return c[0] ? compLow[c[2:1]] : compHigh[c[2:1]];
    endfunction

    task automatic t_reset;
        rd(8'h70, 16'h0000);
        chk_word({29'h0, lineOe}, 32'h0000_0000);
        rd(8'h74, 16'h0000);
    endtask

    task automatic t_pair;
        for (int v = 0; v < 4; v++) begin
            wr(8'h74, 16'hFFFC | 16'(v));
            chk_bit(pair01, v[0]);
            chk_bit(pair23, v[1]);
            rd(8'h74, 16'(v));
        end
    endtask

    // byte lanes: a disabled lane keeps its bits
    task automatic t_lanes;
        sel <= 4'h1;
        wr(8'h70, 16'hFFFF);
        rd(8'h70, 16'h00FF);
        sel <= 4'h2;
        wr(8'h70, 16'h0000);
        rd(8'h70, 16'h00FF);
        wr(8'h74, 16'h0000);
        rd(8'h74, 16'h0003);
        sel <= 4'h3;
        wr(8'h70, 16'h0000);
        rd(8'h70, 16'h0000);
    endtask

    task automatic t_status;
        logic [15:0] e;
        failIn[3] <= 8'h80;
        failIn[0] <= 8'h01;
        terrIn[1] <= 4'h8;
        compHigh <= 4'hA;
        compLow <= 4'h6;
        repeat (5) @(posedge clock);
        e = 16'h0000;
        for (int n = 0; n < NCH; n++) begin
            e[12+n] = |failIn[n];
            e[8+n] = |terrIn[n];
            e[2*n+1] = compHigh[n];
            e[2*n] = compLow[n];
        end
        rd(8'h78, e);
        wr(8'h78, 16'hFFFF);
        rd(8'h78, e);
        rd(8'h7C, 16'h0000);
        rd(8'hF0, 16'h0000);
        failIn <= '0;
        terrIn <= '0;
    endtask

    task automatic t_route;
        logic [2:0] a, b, s;
        for (int c = 0; c < 8; c++) begin
            a = 3'(c);
            b = 3'(c + 3);
            s = 3'(c + 5);
            wr(8'h70, {4'h0, 1'b1, s, 1'b1, b, 1'b1, a});
            for (int p = 0; p < 2; p++) begin
                compHigh <= p ? 4'hA : 4'h5;
                compLow <= p ? 4'hC : 4'h3;
                repeat (2) @(posedge clock);
                chk_bit(busLevel[0], pick(a));
                chk_bit(busLevel[1], pick(b));
                chk_bit(busLevel[2], pick(s));
            end
        end
        wr(8'h70, 16'h0088);
        chk_word({29'h0, lineOe}, 32'h0000_0003);
        chk_bit(lineOut[2], 1'b0);
        wr(8'h70, 16'h0808);
        chk_word({29'h0, lineOe}, 32'h0000_0005);
        chk_bit(lineOut[1], 1'b0);
        // reset in mid-run drops every enable and pairing bit
        arst_n <= 1'b0;
        @(posedge clock);
        chk_word({29'h0, lineOe}, 32'h0000_0000);
        chk_bit(pair01, 1'b0);
        chk_bit(pair23, 1'b0);
        arst_n <= 1'b1;
        rd(8'h70, 16'h0000);
    endtask

    task automatic t_irq;
        wr(8'h80, 16'h00FF);
        wr(8'h84, 16'h0040);
        chk_bit(irq, 1'b0);
        failIn[2] <= 8'h10;
        terrIn[1] <= 4'h2;
        repeat (3) @(posedge clock);
        chk_bit(irq, 1'b1);
        rd(8'h80, 16'h0042);
        wr(8'h80, 16'h0040);
        chk_bit(irq, 1'b0);
        rd(8'h80, 16'h0002);
    endtask

    initial begin
        repeat (3) @(posedge clock);
        arst_n <= 1'b1;
        t_reset;
        t_pair;
        t_lanes;
        t_status;
        t_route;
        t_irq;
        finish_test;
    end
endmodule

`default_nettype wire
